// ==== wss_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_cpu_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic slow_i,
	input  wire logic power_down_i,
	input  wire logic halt_request_i,
	output logic      cpu_clock_o,
	output logic      halt_acknowledge_o
);
	logic [2:0] div_r;
	logic       skip_r;

	// cpu clock, eight system cycles a phase; it stands still in power down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= 3'h0;
			cpu_clock_o <= 1'b0;
		end else if (!power_down_i) begin
			div_r <= div_r + 3'h1;
			if (div_r == 3'h7) cpu_clock_o <= ~cpu_clock_o;
		end
	end

	// ack tracks the request on rising cpu edges; slow mode raises it only on every other rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_acknowledge_o <= 1'b0;
			skip_r <= 1'b0;
		end else if (!power_down_i && div_r == 3'h7 && !cpu_clock_o) begin
			skip_r <= ~skip_r;
			halt_acknowledge_o <= halt_request_i & (halt_acknowledge_o | !slow_i | skip_r);
		end
	end
endmodule
`default_nettype wire

// ==== wss_pkg.sv ====
package wss_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ---------------------------------------------------------------
	localparam logic [9:0] IDX_CLEAR = 10'h0E3;
	localparam logic [9:0] IDX_OSC   = 10'h0E0;
	localparam logic [9:0] IDX_SCR   = 10'h0FF;
	localparam logic [9:0] IDX_VMON  = 10'h1E4;
	localparam logic [9:0] IDX_DUTY  = 10'h1EB;

	// ---------------------------------------------------------------
	// field positions and values
	// ---------------------------------------------------------------
	localparam int SCR_GIE   = 7;
	localparam int SCR_WATCHDOG_RESET_FLAG  = 5;
	localparam int SCR_POWER_ON_FLAG  = 4;
	localparam int SCR_SLEEP = 3;
	localparam int SCR_STOP  = 0;
	localparam int OSC_LOWP  = 7;
	localparam int DUTY_LSB  = 6;
	localparam logic [7:0] CLEAR_BOTH_KEY = 8'h38;
	localparam logic [1:0] WD_LIMIT       = 2'h3;

	// reset values
	localparam logic [1:0] OSC_PERIOD_RST = 2'h0;
	localparam logic [1:0] DUTY_RST       = 2'h0;

	// sleep timer periods in 32 kHz ticks minus one, by period select
	localparam logic [14:0] PERIOD_0 = 15'h003F;
	localparam logic [14:0] PERIOD_1 = 15'h01FF;
	localparam logic [14:0] PERIOD_2 = 15'h0FFF;
	localparam logic [14:0] PERIOD_3 = 15'h7FFF;

	// detector off-time in 32 kHz ticks, by duty select
	localparam logic [8:0] DUTY_0 = 9'h07F;
	localparam logic [8:0] DUTY_1 = 9'h1FF;
	localparam logic [8:0] DUTY_2 = 9'h01F;
	localparam logic [8:0] DUTY_3 = 9'h007;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ        = 40000000;
	localparam int WAKE_MIN_US   = 75;
	localparam int WAKE_MAX_US   = 105;
	localparam int WAKE_MIN_CYC  = (WAKE_MIN_US * (CLK_HZ / 1000000));
	localparam int WAKE_MAX_CYC  = (WAKE_MAX_US * (CLK_HZ / 1000000));

	typedef enum logic [2:0] {
		WSS_AWAKE,
		WSS_REQ,
		WSS_WAIT_FALL,
		WSS_ASLEEP,
		WSS_PD_OFF,
		WSS_SAMPLE,
		WSS_RELEASE
	} wss_state_t;

endpackage

// ==== wss_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the sequencer top
// ------------------------------------------------------------
module wss_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        lp_clk_i,
	input wire logic        cpu_clock_i,
	input wire logic        halt_acknowledge_i,
	input wire logic        halt_request_o,
	input wire logic        power_down_o,
	input wire logic        clk_sel_int_o,
	input wire logic        fast_osc_run_o,
	input wire logic        sleep_tmr_irq_o,
	input wire logic        watchdog_reset_event_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// halt handshake complete on both sides
	sequence s_halted;
		halt_request_o && halt_acknowledge_i;
	endsequence
	// a write that sets the sleep bit, at its ack edge
	sequence s_sleep_wr;
		wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
			&& (wb_adr_i[11:2] == wss_pkg::IDX_SCR) && wb_dat_i[wss_pkg::SCR_SLEEP];
	endsequence

	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	chk_req_on_sleep: assert property (s_sleep_wr |-> ##[1:3] halt_request_o)
		else $error("sleep write gave no halt request");
	chk_pd_after_ack: assert property ($rose(power_down_o) |-> s_halted ##0 !cpu_clock_i)
		else $error("power down without ack or off the falling cpu edge");
	chk_pd_held_req: assert property (power_down_o |-> halt_request_o)
		else $error("power down without halt request");
	chk_pd_osc_off: assert property (power_down_o && $past(power_down_o)
		|-> !fast_osc_run_o && clk_sel_int_o)
		else $error("fast oscillator or clock select wrong in power down");
	chk_pd_drop_rise: assert property ($fell(power_down_o) |-> lp_clk_i
		|| watchdog_reset_event_o || $past(watchdog_reset_event_o))
		else $error("power down released off the rising slow edge");
	chk_req_drop_fall: assert property ($fell(halt_request_o)
		|-> (!lp_clk_i && !power_down_o)
		|| watchdog_reset_event_o || $past(watchdog_reset_event_o))
		else $error("halt request released off the falling slow edge");
	chk_irq_pulse: assert property (sleep_tmr_irq_o |=> !sleep_tmr_irq_o)
		else $error("timer interrupt longer than one cycle");
	chk_wdr_pulse: assert property (watchdog_reset_event_o |=> !watchdog_reset_event_o [*8])
		else $error("watchdog reset pulse repeated");
	cov_wake: cover property ($fell(power_down_o));
endmodule
`default_nettype wire

// ==== wss_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// Contract
// [R1] clearing the power-on flag enables the watchdog permanently
// [R2] power-on reset disables the watchdog until the flag is cleared again
// [R3] sleep timer counts 32 kHz ticks, programmable period, interrupt on overflow
// [R4] watchdog counts timer overflows, resets the chip at three
// [R5] any clear write zeroes watchdog; 0x38 also zeroes the sleep timer
// [R6] sleep entered only via sleep bit; halt until interrupt or reset
// [R7] detector duty-cycled during sleep by the duty field
// [R8] 32 kHz oscillator keeps running in sleep, optional low-power mode
// [R9] any unmasked interrupt wakes regardless of global enable
// [R10] wake only with stop bit clear; stop keeps the CPU halted
// [R11] sleep forces internal clock; fast oscillator restarts on wake
// [R12] after wake the next instruction runs before any interrupt service
// [R13] sleep bit raises halt request at once; CPU samples on rising clock
// [R14] CPU acks next rising edge; power-down asserted on following falling edge
// [R15] power-down stops flash, fast oscillator, filter, bandgap
// [R16] wake interrupt synchronised on a falling 32 kHz edge
// [R17] next rising 32 kHz edge deasserts power-down
// [R18] following rising 32 kHz edge samples power-on and voltage detectors
// [R19] next falling 32 kHz edge drops halt request; CPU drops ack, resumes
// [R20] wake latency from interrupt to CPU running is 75 to 105 us
// [R21] sleep timer interrupt also fires while awake
// [R22] firmware masks non-wake interrupts before sleeping
// [R23] no watchdog reset while the power-on flag is set
// [R24] watchdog reset sets a flag firmware may clear but never set
// [R25] any reset zeroes the watchdog counter and the sleep timer
module wss_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        lp_clk_i,
	input  wire logic        cpu_clock_i,
	input  wire logic        halt_acknowledge_i,
	input  wire logic        irq_pending_i,
	input  wire logic        global_irq_enable_i,
	input  wire logic        ppor_i,
	input  wire logic        low_voltage_detect_i,
	output logic             halt_request_o,
	output logic             power_down_o,
	output logic             clk_sel_int_o,
	output logic             fast_osc_run_o,
	output logic             lp_osc_lowpwr_o,
	output logic             detector_enable_o,
	output logic             sleep_tmr_irq_o,
	output logic             watchdog_reset_event_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	wss_pkg::wss_state_t state_r;
	logic        lp_prev_r;
	logic        cpu_prev_r;
	logic [14:0] sleep_cnt_r;
	logic [1:0]  watchdog_counter_r;
	logic        wd_en_r;
	logic        wd_fire_r;
	logic        power_on_flag_r;
	logic        watchdog_reset_flag_r;
	logic        sleep_r;
	logic        stop_r;
	logic [1:0]  period_r;
	logic        lowp_r;
	logic [1:0]  duty_r;
	logic [8:0]  duty_cnt_r;
	logic        ppor_r;
	logic        lvd_r;
	logic        ack_r;
	logic [31:0] rdat_r;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic       lp_rise;
	logic       lp_fall;
	logic       cpu_rise;
	logic       cpu_fall;
	logic       soft_rst;
	logic [9:0] idx;
	logic       wr_fire;
	logic       wr_lane0;
	logic [7:0] wbyte;
	logic       tmr_ovf;
	logic [14:0] period_max;
	logic [8:0]  duty_max;

	// both clocks are taken as synchronous levels; edges come from the previous sample
	assign lp_rise  = lp_clk_i & ~lp_prev_r;
	assign lp_fall  = ~lp_clk_i & lp_prev_r;
	assign cpu_rise = cpu_clock_i & ~cpu_prev_r;
	assign cpu_fall = ~cpu_clock_i & cpu_prev_r;

	// a watchdog reset reinitialises everything except the reset cause flags, watchdog enable and event, edge history, detector results and bus slave
	assign soft_rst = rst_i | wd_fire_r;
	assign idx      = wb_adr_i[11:2];
	assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign wr_lane0 = wr_fire & wb_sel_i[0];
	assign wbyte    = wb_dat_i[7:0];

	// period and duty lookups
	always_comb begin
		case (period_r)
			2'h0:    period_max = wss_pkg::PERIOD_0;
			2'h1:    period_max = wss_pkg::PERIOD_1;
			2'h2:    period_max = wss_pkg::PERIOD_2;
			default: period_max = wss_pkg::PERIOD_3;
		endcase
		case (duty_r)
			2'h0:    duty_max = wss_pkg::DUTY_0;
			2'h1:    duty_max = wss_pkg::DUTY_1;
			2'h2:    duty_max = wss_pkg::DUTY_2;
			default: duty_max = wss_pkg::DUTY_3;
		endcase
	end

	assign tmr_ovf = lp_rise & (sleep_cnt_r >= period_max);

	// ---------------------------------------------------------------
	// edge history
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_prev_r  <= 1'b0;
			cpu_prev_r <= 1'b0;
		end else begin
			lp_prev_r  <= lp_clk_i;
			cpu_prev_r <= cpu_clock_i;
		end
	end

	// ---------------------------------------------------------------
	// sleep timer
	// ---------------------------------------------------------------
	// runs in every state, so periodic interrupts continue while awake
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			sleep_cnt_r     <= 15'h0000;                     // [R25]
			sleep_tmr_irq_o <= 1'b0;
		end else begin
			sleep_tmr_irq_o <= tmr_ovf;                      // [R3] [R21]
			if (wr_lane0 && idx == wss_pkg::IDX_CLEAR &&
			    wbyte == wss_pkg::CLEAR_BOTH_KEY)
				sleep_cnt_r <= 15'h0000;                     // [R5]
			else if (tmr_ovf)
				sleep_cnt_r <= 15'h0000;                     // [R3]
			else if (lp_rise)
				sleep_cnt_r <= sleep_cnt_r + 15'h0001;
		end
	end

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	// a clear write and an overflow in one cycle: the clear wins, as the write
	// restarts the whole watchdog period
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			watchdog_counter_r <= 2'h0;                      // [R25]
			wd_fire_r          <= 1'b0;
		end else begin
			wd_fire_r <= 1'b0;
			if (wr_fire && idx == wss_pkg::IDX_CLEAR)
				watchdog_counter_r <= 2'h0;                  // [R5]
			else if (tmr_ovf && wd_en_r && !power_on_flag_r) begin
				if (watchdog_counter_r == wss_pkg::WD_LIMIT - 2'h1) begin
					watchdog_counter_r <= 2'h0;
					wd_fire_r          <= 1'b1;              // [R4] [R23]
				end else
					watchdog_counter_r <= watchdog_counter_r + 2'h1;  // [R4]
			end
		end
	end

	// enable survives a watchdog reset; only the power-on reset clears it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wd_en_r <= 1'b0;                                 // [R2]
		else if (!power_on_flag_r)
			wd_en_r <= 1'b1;                                 // [R1]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			watchdog_reset_event_o <= 1'b0;
		else
			watchdog_reset_event_o <= wd_fire_r;
	end

	// ---------------------------------------------------------------
	// reset cause flags
	// ---------------------------------------------------------------
	// firmware can only clear these (write 0); hardware set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			power_on_flag_r       <= 1'b1;                   // [R23]
			watchdog_reset_flag_r <= 1'b0;
		end else begin
			if (wr_lane0 && idx == wss_pkg::IDX_SCR && !wbyte[wss_pkg::SCR_POWER_ON_FLAG])
				power_on_flag_r <= 1'b0;                     // [R1]
			if (wd_fire_r)
				watchdog_reset_flag_r <= 1'b1;               // [R24]
			else if (wr_lane0 && idx == wss_pkg::IDX_SCR && !wbyte[wss_pkg::SCR_WATCHDOG_RESET_FLAG])
				watchdog_reset_flag_r <= 1'b0;               // [R24]
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	// the sleep bit self-clears when the wake sequence releases the CPU
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			sleep_r  <= 1'b0;
			stop_r   <= 1'b0;
			period_r <= wss_pkg::OSC_PERIOD_RST;
			lowp_r   <= 1'b0;
			duty_r   <= wss_pkg::DUTY_RST;
		end else begin
			if (wr_lane0 && idx == wss_pkg::IDX_SCR) begin
				sleep_r <= wbyte[wss_pkg::SCR_SLEEP];        // [R6]
				stop_r  <= wbyte[wss_pkg::SCR_STOP];
			end else if (state_r == wss_pkg::WSS_RELEASE && lp_fall)
				sleep_r <= 1'b0;
			if (wr_lane0 && idx == wss_pkg::IDX_OSC) begin
				period_r <= wbyte[1:0];                      // [R3]
				lowp_r   <= wbyte[wss_pkg::OSC_LOWP];        // [R8]
			end
			if (wr_lane0 && idx == wss_pkg::IDX_DUTY)
				duty_r <= wbyte[wss_pkg::DUTY_LSB +: 2];     // [R7]
		end
	end

	// ---------------------------------------------------------------
	// sleep / wake sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (soft_rst)
			state_r <= wss_pkg::WSS_AWAKE;
		else begin
			case (state_r)
				wss_pkg::WSS_AWAKE:
					if (sleep_r)
						state_r <= wss_pkg::WSS_REQ;         // [R6] [R13]
				wss_pkg::WSS_REQ:
					if (cpu_rise && halt_acknowledge_i)
						state_r <= wss_pkg::WSS_WAIT_FALL;   // [R14]
				wss_pkg::WSS_WAIT_FALL:
					if (cpu_fall)
						state_r <= wss_pkg::WSS_ASLEEP;      // [R14]
				wss_pkg::WSS_ASLEEP:
					// global enable is deliberately not looked at
					if (lp_fall && irq_pending_i && !stop_r)
						state_r <= wss_pkg::WSS_PD_OFF;      // [R9] [R10] [R16]
				wss_pkg::WSS_PD_OFF:
					if (lp_rise)
						state_r <= wss_pkg::WSS_SAMPLE;      // [R17]
				wss_pkg::WSS_SAMPLE:
					if (lp_rise)
						state_r <= wss_pkg::WSS_RELEASE;     // [R18]
				wss_pkg::WSS_RELEASE:
					if (lp_fall)
						state_r <= wss_pkg::WSS_AWAKE;       // [R19] [R20]
				default:
					state_r <= wss_pkg::WSS_AWAKE;
			endcase
		end
	end

	// halt request rises the cycle after the sleep write lands; it stays up
	// through the whole sleep and while the stop bit is set
	always_ff @(posedge clk_i) begin
		if (soft_rst)
			halt_request_o <= 1'b0;
		else if (stop_r)
			halt_request_o <= 1'b1;                          // [R10]
		else if (state_r == wss_pkg::WSS_AWAKE)
			halt_request_o <= sleep_r;                       // [R13]
		else if (state_r == wss_pkg::WSS_RELEASE && lp_fall)
			halt_request_o <= 1'b0;                          // [R19] [R12]
	end

	// power-down and its dependents
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			power_down_o   <= 1'b0;
			fast_osc_run_o <= 1'b1;
			clk_sel_int_o  <= 1'b1;
		end else begin
			if (state_r == wss_pkg::WSS_WAIT_FALL && cpu_fall) begin
				power_down_o   <= 1'b1;                      // [R14] [R15]
				fast_osc_run_o <= 1'b0;                      // [R15]
			end else if (state_r == wss_pkg::WSS_PD_OFF && lp_rise) begin
				power_down_o   <= 1'b0;                      // [R17]
				fast_osc_run_o <= 1'b1;                      // [R11]
			end
			// forced on entry; firmware owns any external clock choice afterwards
			if (state_r == wss_pkg::WSS_REQ)
				clk_sel_int_o <= 1'b1;                       // [R11]
			else if (wr_lane0 && idx == wss_pkg::IDX_OSC)
				clk_sel_int_o <= ~wbyte[2];              // bit 2, clear of the period field
		end
	end

	// low-power oscillator mode bit is passed out; the oscillator itself never stops
	always_ff @(posedge clk_i) begin
		if (soft_rst)
			lp_osc_lowpwr_o <= 1'b0;
		else
			lp_osc_lowpwr_o <= lowp_r;                       // [R8]
	end

	// ---------------------------------------------------------------
	// detector duty cycling
	// ---------------------------------------------------------------
	// on for one 32 kHz period, then off for the chosen count; longer off time
	// saves power at the cost of detection latency
	always_ff @(posedge clk_i) begin
		if (soft_rst) begin
			duty_cnt_r        <= 9'h000;
			detector_enable_o <= 1'b1;
		end else if (!power_down_o) begin
			duty_cnt_r        <= 9'h000;
			detector_enable_o <= 1'b1;
		end else if (lp_rise) begin
			if (duty_cnt_r >= duty_max) begin
				duty_cnt_r        <= 9'h000;
				detector_enable_o <= 1'b1;                   // [R7]
			end else begin
				duty_cnt_r        <= duty_cnt_r + 9'h001;
				detector_enable_o <= 1'b0;                   // [R7]
			end
		end
	end

	// detector results: tracked while awake, sampled once during wake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ppor_r <= 1'b0;
			lvd_r  <= 1'b0;
		end else if ((state_r == wss_pkg::WSS_SAMPLE && lp_rise) ||
		             state_r == wss_pkg::WSS_AWAKE) begin
			ppor_r <= ppor_i;                                // [R18]
			lvd_r  <= low_voltage_detect_i;
		end
	end

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	// one wait state: ack one cycle after stb, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r  <= wb_cyc_i & wb_stb_i & ~ack_r;
			rdat_r <= 32'h0000_0000;
			if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
				case (idx)
					wss_pkg::IDX_SCR:
						rdat_r[7:0] <= {global_irq_enable_i, 1'b0,
						                watchdog_reset_flag_r, power_on_flag_r,
						                sleep_r, 2'h0, stop_r};
					wss_pkg::IDX_OSC:
						rdat_r[7:0] <= {lowp_r, 4'h0, ~clk_sel_int_o, period_r};
					wss_pkg::IDX_DUTY:
						rdat_r[7:0] <= {duty_r, 6'h00};
					wss_pkg::IDX_VMON:
						rdat_r[7:0] <= {6'h00, lvd_r, ppor_r};
					default:
						rdat_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

endmodule

`default_nettype wire

// ==== wss_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_top_test;
	logic        clk_i = 1'b0, rst_i = 1'b1;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h0, rdat, seed = 32'h5B96;
	logic [3:0]  sel = 4'h0;
	logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, irq = 1'b0, global_irq_enable = 1'b0, lp = 1'b0;
	logic        slow = 1'b0, ack, cpu_clk, hack, hreq, pd, csel, fosc, lpw, den, tirq, watchdog_reset_event;
	logic [7:0]  q, d;
	int          bad_count = 0, tests_run = 0, cyc_n = 0, irq_n = 0, wd_n = 0, lp_n = 0, t_mark;
	int          den_n = 0, t_ovf, n_irq;

	always #12.5 clk_i = ~clk_i;

	wss_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.lp_clk_i(lp), .cpu_clock_i(cpu_clk), .halt_acknowledge_i(hack), .irq_pending_i(irq),
		.global_irq_enable_i(global_irq_enable), .ppor_i(1'b0), .low_voltage_detect_i(1'b0),
		.halt_request_o(hreq), .power_down_o(pd), .clk_sel_int_o(csel), .fast_osc_run_o(fosc),
		.lp_osc_lowpwr_o(lpw), .detector_enable_o(den), .sleep_tmr_irq_o(tirq),
		.watchdog_reset_event_o(watchdog_reset_event));
	wss_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .power_down_i(pd),
		.halt_request_i(hreq), .cpu_clock_o(cpu_clk), .halt_acknowledge_o(hack));

	// slow clock made fast (16 cycles) so whole timer periods fit the run
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		lp_n <= (lp_n == 7) ? 0 : lp_n + 1;
		if (lp_n == 7) lp <= ~lp;
		if (tirq === 1'b1) irq_n <= irq_n + 1;
		if (watchdog_reset_event === 1'b1) wd_n <= wd_n + 1;
		if (den === 1'b1 && pd === 1'b1) den_n <= den_n + 1;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [7:0] scr_exp(input logic watchdog_reset_flag, input logic power_on_flag);
		return {global_irq_enable, 1'b0, watchdog_reset_flag, power_on_flag, 4'h0};
	endfunction
	function automatic logic pick(input int s);
		case (s)
			0: return tirq;
			1: return watchdog_reset_event;
			2: return hreq;
			default: return pd;
		endcase
	endfunction

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_rng(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask
	// one classic cycle; q holds read data taken at the ack edge
	task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] v);
		int n;
		@(posedge clk_i);
		adr <= {idx, 2'b00};
		we <= w;
		dat <= {24'h0, v};
		sel <= 4'hF;
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20) bad_count++;
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// bounded wait for an output level; running out counts as a mismatch
	task automatic wait_on(input int s, input logic v, input int lim);
		int n;
		n = 0;
		@(posedge clk_i);
		while (pick(s) !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= lim) bad_count++;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = xs(seed);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		global_irq_enable <= seed[3];
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b0, 1'b1));
		bus(wss_pkg::IDX_OSC, 1'b0, 8'h00);
		check_val(q, 8'h00);
		bus(wss_pkg::IDX_DUTY, 1'b0, 8'h00);
		check_val(q, 8'h00);
		bus(10'h3A5, 1'b1, 8'hFF);
		bus(10'h3A5, 1'b0, 8'h00);
		check_val(q, 8'h00);
		wait_on(0, 1'b1, 1200);
		t_mark = cyc_n;
		wait_on(0, 1'b1, 1200);
		check_rng(cyc_n - t_mark, 1024, 1024);
		repeat (2) wait_on(0, 1'b1, 1200);
		check_val(wd_n[7:0], 8'h00);
		bus(wss_pkg::IDX_SCR, 1'b1, 8'h00);
		repeat (2) wait_on(0, 1'b1, 1200);
		check_val(wd_n[7:0], 8'h00);
		wait_on(1, 1'b1, 1100);
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b1, 1'b0));
		bus(wss_pkg::IDX_SCR, 1'b1, 8'h30);
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b1, 1'b0));
		bus(wss_pkg::IDX_SCR, 1'b1, 8'h00);
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b0, 1'b0));
		t_mark = wd_n;
		n_irq = irq_n;
		// random clear values after each overflow keep the watchdog quiet
		// and must leave the sleep timer on its old period
		for (int i = 0; i < 4; i++) begin
			wait_on(0, 1'b1, 1200);
			if (i > 0) check_rng(cyc_n - t_ovf, 1024, 1024);
			t_ovf = cyc_n;
			seed = xs(seed);
			d = (seed[7:0] == 8'h38) ? 8'h00 : seed[7:0];
			bus(wss_pkg::IDX_CLEAR, 1'b1, d);
		end
		check_val(8'(wd_n - t_mark), 8'h00);
		check_val(8'(irq_n - n_irq), 8'h04);
		repeat (500) @(posedge clk_i);
		bus(wss_pkg::IDX_CLEAR, 1'b1, 8'h38);
		t_mark = cyc_n;
		wait_on(0, 1'b1, 1200);
		check_rng(cyc_n - t_mark, 1000, 1030);
		seed = xs(seed);
		global_irq_enable <= 1'b0;
		slow <= seed[2];
		// external clock chosen before sleep; entry must force the internal one
		bus(wss_pkg::IDX_OSC, 1'b1, 8'h04);
		bus(wss_pkg::IDX_OSC, 1'b0, 8'h00);
		check_val(q, 8'h04);
		bus(wss_pkg::IDX_CLEAR, 1'b1, 8'h38);
		bus(wss_pkg::IDX_SCR, 1'b1, 8'h08);
		wait_on(2, 1'b1, 20);
		wait_on(3, 1'b1, 200);
		repeat (200) @(posedge clk_i);
		check_val({5'h0, pd, csel, fosc}, 8'h06);
		irq <= 1'b1;
		t_mark = cyc_n;
		wait_on(3, 1'b0, 100);
		wait_on(2, 1'b0, 100);
		check_rng(cyc_n - t_mark, 32, 56);
		check_val({6'h0, csel, fosc}, 8'h03);
		irq <= 1'b0;
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b0, 1'b0));
		bus(wss_pkg::IDX_OSC, 1'b1, 8'h80);
		repeat (2) @(posedge clk_i);
		check_val({6'h0, lpw, den}, 8'h03);
		bus(wss_pkg::IDX_DUTY, 1'b1, 8'hC0);
		bus(wss_pkg::IDX_DUTY, 1'b0, 8'h00);
		check_val(q, 8'hC0);
		bus(wss_pkg::IDX_CLEAR, 1'b1, 8'h38);
		bus(wss_pkg::IDX_SCR, 1'b1, 8'h09);
		wait_on(3, 1'b1, 200);
		irq <= 1'b1;
		repeat (100) @(posedge clk_i);
		check_val({6'h0, hreq, pd}, 8'h03);
		// duty code 3: one slow period on in every eight, so 32 of 256 cycles
		t_mark = den_n;
		repeat (256) @(posedge clk_i);
		check_rng(den_n - t_mark, 32, 32);
		wait_on(1, 1'b1, 4000);
		repeat (3) @(posedge clk_i);
		check_val({6'h0, hreq, pd}, 8'h00);
		irq <= 1'b0;
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b1, 1'b0));
		// a second power-on reset in mid-run must disable the watchdog again
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(wss_pkg::IDX_SCR, 1'b0, 8'h00);
		check_val(q, scr_exp(1'b0, 1'b1));
		t_mark = wd_n;
		repeat (3) wait_on(0, 1'b1, 1200);
		check_val(8'(wd_n - t_mark), 8'h00);
		results();
	end

	// the run needs about 19300 cycles; the watchdog allows well over twice that
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		results();
	end
endmodule

bind wss_top wss_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lp_clk_i(lp_clk_i),
	.cpu_clock_i(cpu_clock_i), .halt_acknowledge_i(halt_acknowledge_i),
	.halt_request_o(halt_request_o), .power_down_o(power_down_o),
	.clk_sel_int_o(clk_sel_int_o), .fast_osc_run_o(fast_osc_run_o),
	.sleep_tmr_irq_o(sleep_tmr_irq_o), .watchdog_reset_event_o(watchdog_reset_event_o));
`default_nettype wire
